// >>> hw/mhf_filter_mgmt.sv
// Purpose: Group address hash filter and indirect PHY management registers.
// Assumes: Plain register port with read data one cycle after the strobe.
// Notes: Writes to the access or data register while busy are dropped.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module mhf_filter_mgmt
  import mhf_pkg::*;
#(
  parameter int HALF_CYC = MDC_HALF_CYC
) (
  input wire logic ref_clk, // System clock, 50 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, one cycle after reg_rd.
  input wire logic rx_dest_valid, // Destination address present, one cycle.
  input wire logic [47:0] rx_dest_addr, // Destination address, first byte in 47:40.
  output logic filter_valid, // Verdict strobe.
  output logic filter_group, // Address was a group address.
  output logic filter_accept, // Group frame accepted.
  output logic mdc, // Management clock to the PHY.
  input wire logic mdio_in, // MDIO pin level.
  output logic mdio_out, // MDIO drive value.
  output logic mdio_oe // MDIO drive enable.
);
  logic [31:0] hash_high_q, hash_high_d, hash_low_q, hash_low_d;
  logic [4:0] phy_addr_q, phy_addr_d, reg_idx_q, reg_idx_d;
  logic write_sel_q, write_sel_d, busy_q, busy_d;
  logic [15:0] data_q, data_d;
  logic pass_all_q, pass_all_d;
  logic start_q, start_d, done_dly_q, done_dly_d;
  logic [31:0] rdata_d;
  logic valid_d, group_d, accept_d;
  logic sync1_q, sync2_q, sync3_q, mdio_lvl_q, mdio_lvl_d;
  logic [5:0] hash_index;
  logic hash_bit;
  logic eng_done;
  logic [15:0] eng_rdata;
  logic wr_acc, wr_data;

  assign wr_acc = reg_wr && reg_addr == ADDR_PHY_ACC;
  assign wr_data = reg_wr && reg_addr == ADDR_PHY_DATA;

  // Only the agreed level of the second and third stages moves the filtered input.
  always_comb begin
    mdio_lvl_d = (sync2_q == sync3_q) ? sync3_q : mdio_lvl_q;
  end

  // Three-stage synchroniser for the pin.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      mdio_lvl_q <= 1'b1;
    end else begin
      sync1_q <= mdio_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      mdio_lvl_q <= mdio_lvl_d;
    end
  end

  // Register writes, start and completion of a management access.
  always_comb begin
    hash_high_d = hash_high_q;
    hash_low_d = hash_low_q;
    phy_addr_d = phy_addr_q;
    reg_idx_d = reg_idx_q;
    write_sel_d = write_sel_q;
    busy_d = busy_q;
    data_d = data_q;
    pass_all_d = pass_all_q;
    start_d = 1'b0;
    done_dly_d = eng_done;
    if (reg_wr && reg_addr == ADDR_HASH_HIGH) begin
      hash_high_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_HASH_LOW) begin
      hash_low_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_FILT_CTRL) begin
      pass_all_d = reg_wdata[CTRL_PASS_ALL_BIT];
    end
    // Writes during an access are dropped, so a careless driver cannot corrupt it.
    if (wr_acc && !busy_q) begin
      phy_addr_d = reg_wdata[ACC_PHY_ADDR_LSB +: 5];
      reg_idx_d = reg_wdata[ACC_REG_IDX_LSB +: 5];
      write_sel_d = reg_wdata[ACC_WRITE_BIT];
      busy_d = reg_wdata[ACC_BUSY_BIT];
      start_d = reg_wdata[ACC_BUSY_BIT];
    end
    if (wr_data && !busy_q) begin
      data_d = reg_wdata[15:0];
    end
    // Read data lands on the done cycle, busy falls one cycle later.
    if (eng_done && !write_sel_q) begin
      data_d = eng_rdata;
    end
    if (done_dly_q) begin
      busy_d = 1'b0;
    end
  end

  // Register state.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hash_high_q <= HASH_RST;
      hash_low_q <= HASH_RST;
      phy_addr_q <= PHY_FIELD_RST;
      reg_idx_q <= PHY_FIELD_RST;
      write_sel_q <= 1'b0;
      busy_q <= 1'b0;
      data_q <= PHY_DATA_RST;
      pass_all_q <= CTRL_PASS_ALL_RST;
      start_q <= 1'b0;
      done_dly_q <= 1'b0;
    end else begin
      hash_high_q <= hash_high_d;
      hash_low_q <= hash_low_d;
      phy_addr_q <= phy_addr_d;
      reg_idx_q <= reg_idx_d;
      write_sel_q <= write_sel_d;
      busy_q <= busy_d;
      data_q <= data_d;
      pass_all_q <= pass_all_d;
      start_q <= start_d;
      done_dly_q <= done_dly_d;
    end
  end

  // Read path; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_HASH_HIGH: rdata_d = hash_high_q;
        ADDR_HASH_LOW: rdata_d = hash_low_q;
        ADDR_PHY_ACC: begin
          rdata_d[ACC_PHY_ADDR_LSB +: 5] = phy_addr_q;
          rdata_d[ACC_REG_IDX_LSB +: 5] = reg_idx_q;
          rdata_d[ACC_WRITE_BIT] = write_sel_q;
          rdata_d[ACC_BUSY_BIT] = busy_q;
        end
        ADDR_PHY_DATA: rdata_d[15:0] = data_q;
        ADDR_FILT_CTRL: rdata_d[CTRL_PASS_ALL_BIT] = pass_all_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for one cycle only, so a stale word never looks like a fresh answer.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  mhf_dest_hash u_hash (
    .dest_addr(rx_dest_addr),
    .hash_index(hash_index)
  );

  // Index bit 5 picks the register, bits 4:0 the bit within it.
  assign hash_bit = hash_index[5] ? hash_high_q[hash_index[4:0]]
                                  : hash_low_q[hash_index[4:0]];

  // Verdict, one cycle after the address. Individual addresses are not judged here.
  always_comb begin
    valid_d = rx_dest_valid;
    group_d = rx_dest_valid && rx_dest_addr[GROUP_ADDR_BIT];
    accept_d = group_d && (pass_all_q || hash_bit);
  end

  // Verdict registers, so the receive path sees clean flip-flop outputs.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      filter_valid <= 1'b0;
      filter_group <= 1'b0;
      filter_accept <= 1'b0;
    end else begin
      filter_valid <= valid_d;
      filter_group <= group_d;
      filter_accept <= accept_d;
    end
  end

  mhf_mdio_engine #(
    .HALF_CYC(HALF_CYC)
  ) u_mdio (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(start_q),
    .write_sel(write_sel_q),
    .phy_addr(phy_addr_q),
    .reg_idx(reg_idx_q),
    .wdata(data_q),
    .mdio_lvl(mdio_lvl_q),
    .done(eng_done),
    .rdata(eng_rdata),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe)
  );

  property p_index_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    rx_dest_valid && rx_dest_addr[GROUP_ADDR_BIT] && !pass_all_q && hash_index == 6'h00
    |=> filter_accept == $past(hash_low_q[0]);
  endproperty
  a_index_zero: assert property (p_index_zero) else $error("Index 0 not low bit 0");

  property p_index_max;
    @(posedge ref_clk) disable iff (!reset_n)
    rx_dest_valid && rx_dest_addr[GROUP_ADDR_BIT] && !pass_all_q && hash_index == 6'h3f
    |=> filter_accept == $past(hash_high_q[31]);
  endproperty
  a_index_max: assert property (p_index_max) else $error("Index 63 not high bit 31");

  property p_pass_all;
    @(posedge ref_clk) disable iff (!reset_n)
    rx_dest_valid && rx_dest_addr[GROUP_ADDR_BIT] && pass_all_q |=> filter_valid && filter_accept;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("Pass-all frame rejected");

  property p_hash_readback;
    @(posedge ref_clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_HASH_HIGH ##1 reg_rd && reg_addr == ADDR_HASH_HIGH
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_hash_readback: assert property (p_hash_readback) else $error("Hash high readback wrong");

  property p_busy_start;
    @(posedge ref_clk) disable iff (!reset_n)
    wr_acc && !busy_q && reg_wdata[ACC_BUSY_BIT] |=> busy_q && start_q;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("Access did not start");

  property p_read_before_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    eng_done && !write_sel_q |=> busy_q && data_q == $past(eng_rdata) ##1 !busy_q;
  endproperty
  a_read_before_clear: assert property (p_read_before_clear)
    else $error("Busy cleared early");

  property p_data_upper_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_PHY_DATA |=> reg_rdata[31:16] == 16'h0000;
  endproperty
  a_data_upper_zero: assert property (p_data_upper_zero)
    else $error("Reserved data bits set");

  property p_low_write;
    @(posedge ref_clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_HASH_LOW |=> hash_low_q == $past(reg_wdata);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("Hash low write lost");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data left standing");

  property p_group_flag;
    @(posedge ref_clk) disable iff (!reset_n)
    rx_dest_valid |=> filter_valid && filter_group == $past(rx_dest_addr[GROUP_ADDR_BIT]);
  endproperty
  a_group_flag: assert property (p_group_flag)
    else $error("Group flag wrong");

  property p_individual_reject;
    @(posedge ref_clk) disable iff (!reset_n)
    rx_dest_valid && !rx_dest_addr[GROUP_ADDR_BIT] |=> !filter_accept;
  endproperty
  a_individual_reject: assert property (p_individual_reject)
    else $error("Individual frame accepted");

  property p_write_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    eng_done && write_sel_q |=> busy_q ##1 !busy_q;
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("Busy not cleared after write");

  property p_start_frame;
    @(posedge ref_clk) disable iff (!reset_n)
    start_q |=> mdio_oe && mdio_out && !mdc;
  endproperty
  a_start_frame: assert property (p_start_frame)
    else $error("Frame did not start");
endmodule : mhf_filter_mgmt

// >>> hw/mhf_pkg.sv
// Purpose: Shared constants for the group hash filter and PHY management slice.
// Assumes: One 50 MHz clock; register indices map to byte address index times four.
// Notes: Index 0xa holds the filter control register.
package mhf_pkg;
  // Register indices and their byte addresses.
  localparam logic [3:0] IDX_HASH_HIGH = 4'h4;
  localparam logic [3:0] IDX_HASH_LOW = 4'h5;
  localparam logic [3:0] IDX_PHY_ACC = 4'h6;
  localparam logic [3:0] IDX_PHY_DATA = 4'h7;
  localparam logic [3:0] IDX_FILT_CTRL = 4'ha;
  localparam logic [7:0] ADDR_HASH_HIGH = {2'h0, IDX_HASH_HIGH, 2'h0};
  localparam logic [7:0] ADDR_HASH_LOW = {2'h0, IDX_HASH_LOW, 2'h0};
  localparam logic [7:0] ADDR_PHY_ACC = {2'h0, IDX_PHY_ACC, 2'h0};
  localparam logic [7:0] ADDR_PHY_DATA = {2'h0, IDX_PHY_DATA, 2'h0};
  localparam logic [7:0] ADDR_FILT_CTRL = {2'h0, IDX_FILT_CTRL, 2'h0};
  // Field positions.
  localparam int ACC_PHY_ADDR_LSB = 11;
  localparam int ACC_REG_IDX_LSB = 6;
  localparam int ACC_WRITE_BIT = 1;
  localparam int ACC_BUSY_BIT = 0;
  localparam int CTRL_PASS_ALL_BIT = 0;
  localparam int GROUP_ADDR_BIT = 40;
  // Reset values.
  localparam logic [31:0] HASH_RST = 32'h0000_0000;
  localparam logic [15:0] PHY_DATA_RST = 16'h0000;
  localparam logic [4:0] PHY_FIELD_RST = 5'h00;
  localparam logic CTRL_PASS_ALL_RST = 1'b0;
  // Management frame timing and layout.
  localparam int CLK_NS = 20;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] FRAME_LAST_BIT = 6'h3f;
  localparam logic [5:0] FRAME_TA_BIT = 6'h2e;
  localparam logic [5:0] FRAME_DATA_BIT = 6'h30;
  localparam logic [31:0] MDIO_PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] MDIO_START = 2'h1;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_TA_WRITE = 2'h2;
  // Reflected CRC-32 polynomial, bits enter least significant first.
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

  typedef enum {MDIO_IDLE, MDIO_RUN} mhf_mdio_state_t;
endpackage : mhf_pkg

// >>> hw/mhf_dest_hash.sv
// Purpose: Six-bit group hash index from a destination address.
// Assumes: Address bits 47:40 are the first byte on the wire.
// Notes: Purely combinational; the caller registers the verdict.
`timescale 1ns/1ps
module mhf_dest_hash
  import mhf_pkg::*;
(
  input wire logic [47:0] dest_addr, // Destination address, first byte in 47:40.
  output logic [5:0] hash_index // Upper six bits of the CRC.
);
  // Bytes go out first-byte-first, each byte least significant bit first.
  always_comb begin
    logic [31:0] crc;
    logic fb;
    crc = CRC_INIT;
    fb = 1'b0;
    for (int b = 0; b < 6; b++) begin
      for (int i = 0; i < 8; i++) begin
        fb = crc[0] ^ dest_addr[47 - 8 * b - 7 + i];
        crc = {1'b0, crc[31:1]} ^ (fb ? CRC_POLY_REFL : 32'h0000_0000);
      end
    end
    // The reflected register holds the top CRC bits at its low end.
    for (int k = 0; k < 6; k++) begin
      hash_index[5 - k] = crc[k];
    end
  end
endmodule : mhf_dest_hash

// >>> hw/mhf_mdio_engine.sv
// Purpose: Serial management frame generator for PHY register access.
// Assumes: start arrives only while idle; mdio_lvl is already synchronised.
// Notes: Data changes after MDC falls and is sampled as MDC rises.
`timescale 1ns/1ps
module mhf_mdio_engine
  import mhf_pkg::*;
#(
  parameter int HALF_CYC = MDC_HALF_CYC
) (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic start, // One-cycle request to run a frame.
  input wire logic write_sel, // High for a PHY write.
  input wire logic [4:0] phy_addr, // Target PHY address.
  input wire logic [4:0] reg_idx, // Target PHY register.
  input wire logic [15:0] wdata, // Write data.
  input wire logic mdio_lvl, // Filtered MDIO input level.
  output logic done, // One-cycle pulse when the frame ends.
  output logic [15:0] rdata, // Read data, valid with done.
  output logic mdc, // Management clock.
  output logic mdio_out, // MDIO output value.
  output logic mdio_oe // MDIO output enable.
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

  mhf_mdio_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [5:0] bit_q, bit_d, nxt;
  logic [63:0] frame_q, frame_d;
  logic wr_q, wr_d, mdc_d, out_d, oe_d, done_d;
  logic [15:0] rdata_d;

  assign nxt = bit_q + 6'h01;

  // Frame sequencer: one bit per MDC period, 64 bits per frame.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    frame_d = frame_q;
    wr_d = wr_q;
    mdc_d = mdc;
    out_d = mdio_out;
    oe_d = mdio_oe;
    done_d = 1'b0;
    rdata_d = rdata;
    case (state_q)
      MDIO_IDLE: begin
        if (start) begin
          frame_d = {MDIO_PREAMBLE, MDIO_START, write_sel ? MDIO_OP_WRITE : MDIO_OP_READ,
                     phy_addr, reg_idx, write_sel ? MDIO_TA_WRITE : 2'h0,
                     write_sel ? wdata : 16'h0000};
          wr_d = write_sel;
          bit_d = 6'h00;
          cnt_d = '0;
          mdc_d = 1'b0;
          out_d = 1'b1;
          oe_d = 1'b1;
          state_d = MDIO_RUN;
        end
      end
      MDIO_RUN: begin
        if (cnt_q == HALF_LAST) begin
          cnt_d = '0;
          if (!mdc) begin
            mdc_d = 1'b1;
            if (!wr_q && bit_q >= FRAME_DATA_BIT) begin
              rdata_d = {rdata[14:0], mdio_lvl};
            end
          end else begin
            mdc_d = 1'b0;
            if (bit_q == FRAME_LAST_BIT) begin
              oe_d = 1'b0;
              out_d = 1'b0;
              done_d = 1'b1;
              state_d = MDIO_IDLE;
            end else begin
              bit_d = nxt;
              out_d = frame_q[~nxt];
              oe_d = wr_q || (nxt < FRAME_TA_BIT);
            end
          end
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: state_d = MDIO_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= MDIO_IDLE;
      cnt_q <= '0;
      bit_q <= 6'h00;
      frame_q <= 64'h0;
      wr_q <= 1'b0;
      mdc <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      frame_q <= frame_d;
      wr_q <= wr_d;
      mdc <= mdc_d;
      mdio_out <= out_d;
      mdio_oe <= oe_d;
      done <= done_d;
      rdata <= rdata_d;
    end
  end

  property p_phy_addr_loaded;
    @(posedge ref_clk) disable iff (!reset_n)
    state_q == MDIO_IDLE && start
    |=> frame_q[27:23] == $past(phy_addr) && frame_q[22:18] == $past(reg_idx);
  endproperty
  a_phy_addr_loaded: assert property (p_phy_addr_loaded)
    else $error("PHY fields not loaded");

  property p_read_release;
    @(posedge ref_clk) disable iff (!reset_n)
    state_q == MDIO_RUN && !wr_q && bit_q >= FRAME_TA_BIT |-> !mdio_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("MDIO driven during read");
endmodule : mhf_mdio_engine

// >>> test/mhf_phy_model.sv
// Purpose: Behavioural PHY management responder for the filter bench.
// Assumes: MDC idles low between frames; the MDIO line has a pull-up.
// Notes: Keeps the last 64 line samples so the bench can judge whole frames.
`timescale 1ns/1ps
module mhf_phy_model (
  input wire logic mdc, // Management clock from the device.
  input wire logic mdio, // Resolved MDIO line level.
  input wire logic [15:0] rd_value, // Value returned on reads.
  output logic phy_oe, // High while the model drives MDIO.
  output logic phy_out, // Model drive value.
  output logic [63:0] frame // Last 64 line samples, first bit highest.
);
  int cnt = 0;
  logic is_rd = 1'b0;

  // Start released, so the pull-up holds the line high.
  initial begin
    phy_oe = 1'b0;
    phy_out = 1'b1;
    frame = '0;
  end

  // Sample on the rising edge like a real PHY; a frame is 64 bits long.
  always @(posedge mdc) begin
    frame <= {frame[62:0], mdio};
    if (cnt == 36) begin
      is_rd <= (frame[1:0] == 2'b10);
    end
    cnt <= (cnt == 63) ? 0 : cnt + 1;
  end

  // Drive after the fall so the level is settled long before the next rise.
  always @(negedge mdc) begin
    phy_oe <= is_rd && cnt >= 47;
    phy_out <= (cnt >= 48) ? rd_value[63 - cnt] : 1'b0;
  end
endmodule : mhf_phy_model

// >>> test/mhf_filter_mgmt_tb.sv
// Purpose: Self-checking bench for the group hash filter and PHY management registers.
// Assumes: Default management clock divider; MDIO pulled up when nobody drives it.
// Notes: Filter verdicts are predicted by a local CRC model, not by the design's.
`timescale 1ns/1ps
module mhf_filter_mgmt_tb
  import mhf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic rx_dest_valid = 1'b0;
  logic [47:0] rx_dest_addr = '0;
  logic filter_valid, filter_group, filter_accept;
  logic mdc, mdio_out, mdio_oe, phy_oe, phy_out, mdio_line;
  logic [15:0] rd_value = '0;
  logic [63:0] frame;
  logic [32:0] rd_q[$];
  logic [1:0] filt_q[$];
  logic [32:0] e;
  logic rd_d = 1'b0;
  logic [31:0] v;
  logic [63:0] table_v = '0;
  logic pass_all = 1'b0;
  logic [7:0] regs[6] = '{ADDR_HASH_HIGH, ADDR_HASH_LOW, ADDR_PHY_ACC, ADDR_PHY_DATA,
                          ADDR_FILT_CTRL, 8'h3c};
  logic [4:0] ph, ri;
  logic [15:0] dt;
  logic [63:0] exp_frame;
  int n_errors = 0;
  int cmp_count = 0;

  // The pull-up wins only when neither side drives the line.
  assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

  always #10 ref_clk = ~ref_clk;

  mhf_filter_mgmt i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_dest_valid(rx_dest_valid), .rx_dest_addr(rx_dest_addr), .filter_valid(filter_valid),
    .filter_group(filter_group), .filter_accept(filter_accept), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  mhf_phy_model i_phy (.mdc(mdc), .mdio(mdio_line), .rd_value(rd_value), .phy_oe(phy_oe),
    .phy_out(phy_out), .frame(frame));

  task automatic report(string what, logic [63:0] exp, logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : report

  task automatic cmp_reg(logic [31:0] exp, logic [31:0] got);
    report("reg_rdata", 64'(exp), 64'(got));
  endtask : cmp_reg

  task automatic cmp_filt(logic [1:0] exp, logic [1:0] got);
    report("filter_group_accept", 64'(exp), 64'(got));
  endtask : cmp_filt

  task automatic cmp_frame(logic [63:0] exp, logic [63:0] got);
    report("mdio_frame", exp, got);
  endtask : cmp_frame

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Watcher: read data stands only in the cycle after the strobe.
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e[32]) cmp_reg(e[31:0], reg_rdata);
    end
    if (filter_valid === 1'b1) begin
      if (filt_q.size() == 0) begin
        n_errors++;
        $display("mismatch filter_valid expected 0 seen 1");
      end else begin
        cmp_filt(filt_q.pop_front(), {filter_group, filter_accept});
      end
    end
  end

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Write then read the same register with no gap between the strobes.
  task automatic wr_rd(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    rd_q.push_back({1'b1, d});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : wr_rd

  // Sample 1 ns after the answer edge, once the registered data has landed.
  task automatic rd(logic [7:0] a, logic chk, logic [31:0] exp, output logic [31:0] r);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back({chk, exp});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd

  // Software may touch the access or data register only once busy reads zero.
  task automatic wait_idle();
    int i = 0;
    v = 32'h1;
    while (v[ACC_BUSY_BIT] !== 1'b0 && i < 1000) begin
      rd(ADDR_PHY_ACC, 1'b0, '0, v);
      i++;
    end
    if (i == 1000) begin
      n_errors++;
      $display("mismatch phy_access_busy expected 0 seen %b", v[ACC_BUSY_BIT]);
    end
  endtask : wait_idle

  // Bytes go first-byte first, each byte least significant bit first.
  function automatic logic [5:0] hash_of(logic [47:0] a);
    logic [31:0] c = CRC_INIT;
    logic fb;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[0] ^ a[40 - 8 * k + j];
        c = (c >> 1) ^ (fb ? CRC_POLY_REFL : 32'h0);
      end
    end
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : hash_of

  // Searching is cheap here and reaches the boundary indices without a table.
  function automatic logic [47:0] find_addr(logic [5:0] want);
    logic [47:0] a = '0;
    for (int i = 0; i < 5000; i++) begin
      a = {16'($urandom), $urandom};
      a[GROUP_ADDR_BIT] = 1'b1;
      if (hash_of(a) == want) break;
    end
    return a;
  endfunction : find_addr

  task automatic send(logic [47:0] a);
    logic g;
    g = a[GROUP_ADDR_BIT];
    @(posedge ref_clk);
    rx_dest_valid <= 1'b1;
    rx_dest_addr <= a;
    filt_q.push_back({g, g & (pass_all | table_v[hash_of(a)])});
    @(posedge ref_clk);
    rx_dest_valid <= 1'b0;
  endtask : send

  task automatic set_table(logic [63:0] t);
    table_v = t;
    wr_rd(ADDR_HASH_HIGH, t[63:32]);
    wr(ADDR_HASH_LOW, t[31:0]);
    rd(ADDR_HASH_HIGH, 1'b1, t[63:32], v);
    rd(ADDR_HASH_LOW, 1'b1, t[31:0], v);
  endtask : set_table

  initial begin
    v = $urandom(32'h370d);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, then reserved bits and an unmapped place.
    foreach (regs[i]) rd(regs[i], 1'b1, 32'h0, v);
    wr(ADDR_PHY_ACC, 32'hffff_fffe);
    rd(ADDR_PHY_ACC, 1'b1, 32'h0000_ffc2, v);
    wr(ADDR_PHY_DATA, 32'hffff_ffff);
    rd(ADDR_PHY_DATA, 1'b1, 32'h0000_ffff, v);
    wr(8'h3c, $urandom);
    rd(8'h3c, 1'b1, 32'h0, v);
    // Random table and addresses, group and individual mixed.
    set_table({$urandom, $urandom});
    repeat (40) send({16'($urandom), $urandom});
    // One-hot ends of the table against the four edge indices.
    set_table(64'h8000_0000_0000_0001);
    send(find_addr(6'h00));
    send(find_addr(6'h3f));
    send(find_addr(6'h1f));
    send(find_addr(6'h20));
    set_table('0);
    wr(ADDR_FILT_CTRL, 32'h1);
    pass_all = 1'b1;
    repeat (8) send({16'($urandom), $urandom});
    wr(ADDR_FILT_CTRL, 32'h0);
    pass_all = 1'b0;
    send(find_addr(6'h00));
    // A write to the integrated PHY, then a read from a random address.
    for (int k = 0; k < 2; k++) begin
      ph = (k == 0) ? 5'h01 : 5'($urandom);
      ri = 5'($urandom);
      dt = 16'($urandom);
      rd_value = 16'($urandom);
      wait_idle();
      if (k == 0) wr(ADDR_PHY_DATA, {16'h0, dt});
      wr(ADDR_PHY_ACC, {16'h0, ph, ri, 4'h0, 1'(k == 0), 1'b1});
      rd(ADDR_PHY_ACC, 1'b1, {16'h0, ph, ri, 4'h0, 1'(k == 0), 1'b1}, v);
      wait_idle();
      exp_frame = {MDIO_PREAMBLE, MDIO_START, (k == 0) ? MDIO_OP_WRITE : MDIO_OP_READ, ph, ri,
        MDIO_TA_WRITE, (k == 0) ? dt : rd_value};
      cmp_frame(exp_frame, frame);
      rd(ADDR_PHY_DATA, 1'b1, {16'h0, (k == 0) ? dt : rd_value}, v);
    end
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end

  // Watchdog: the sequence needs about 2800 cycles.
  initial begin
    #400000;
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    give_verdict();
  end
endmodule : mhf_filter_mgmt_tb
